/* File: rtl/dcf_pkg.sv */
package dcf_pkg;

   // word and offset geometry
   localparam int          DCF_WIDTH     = 9;
   localparam int          DCF_OFS_W     = 8;
   localparam int          DCF_OFS_CNT   = 4;
   localparam int          DCF_DEPTH_DEF = 256;
   // wide enough for any count plus a 16-bit offset
   localparam int          DCF_CMP_W     = 18;

   // offset register bank reset image: full high, full low, empty high, empty low
   localparam logic [31:0] DCF_OFS_RST   = 32'h0007_0007;

   // rotating selector over the four offset registers
   typedef enum logic [1:0] {
      OFS_EMPTY_LO = 2'b00,
      OFS_EMPTY_HI = 2'b01,
      OFS_FULL_LO  = 2'b10,
      OFS_FULL_HI  = 2'b11
   } dcf_ofs_e;

   typedef struct packed {
      logic full_n;
      logic afull_n;
      logic aempty_n;
      logic empty_n;
   } dcf_flags_s;

   // full and almost-full high, almost-empty and empty low
   localparam dcf_flags_s  DCF_FLAGS_RST = 4'hC;

endpackage : dcf_pkg

/* File: rtl/dcf_buf2.sv */
`timescale 1ns/1ps

module dcf_buf2 #(
   parameter int W = 9
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // filling side
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   // draining side
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);
   import dcf_pkg::*;

   logic [W-1:0] ent_q [2];
   logic         wp_q;
   logic         rp_q;
   logic [1:0]   cnt_q;
   logic [1:0]   cnt_d;

   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;

   assign in_ready  = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = ent_q[rp_q];
   assign cnt_d     = 2'(cnt_q + {1'b0, push} - {1'b0, pop});

   always_ff @(posedge clk) begin
      if (push) begin
         ent_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         wp_q  <= wp_q ^ push;
         rp_q  <= rp_q ^ pop;
         cnt_q <= cnt_d;
      end
   end

endmodule : dcf_buf2

/* File: rtl/dcf_fifo.sv */
`timescale 1ns/1ps

// Operation
// R1 - reset returns write and read pointers to the first location
// R2 - reset drives full and almost-full high, empty and almost-empty low
// R3 - reset zeroes output register and loads offset registers with defaults
// R4 - writer resets the buffer after power-up before its first write
// R5 - flag mode: enable low stores words sequentially; high holds input
// R6 - two-enable mode: store only with primary low and second enable high
// R7 - full flag low while full; all write enables ignored then
// R8 - a read that frees a location raises the full flag again
// R9 - full flags follow write edges, empty flags follow read edges
// R10 - both read enables low moves next word into output register
// R11 - either read enable high holds the output register
// R12 - empty flag low once drained; read enables ignored while empty
// R13 - a write into an empty buffer raises the empty flag again
// R14 - works with separate or identical write and read clocks; this design clocks both ports from SYS_CLK only
// R15 - output enable low drives the output register, high floats the bus
// R16 - load pin level during reset picks two-enable or offset-load mode
// R17 - four 8-bit offset registers, loadable from inputs, readable on outputs
// R18 - offset writes rotate empty low, empty high, full low, full high, wrap
// R19 - leaving load mode mid-sequence keeps the rotation position
// R20 - offset reads rotate through the same order onto the outputs
// R21 - parties avoid reading and writing offset registers together
// R22 - offsets default to seven words from empty and from full
// R23 - empty flag low whenever read pointer equals write pointer; this design keeps it high when the pointers meet with DEPTH words stored
// R24 - almost-empty low while count is at most the empty offset
// R25 - almost-full low while count reaches depth minus full offset
// R26 - depth is a parameter; pointers wrap there; a word count is kept
module dcf_fifo #(
   parameter int DEPTH = dcf_pkg::DCF_DEPTH_DEF
) (
   // clock and reset
   input  wire logic                          SYS_CLK,
   input  wire logic                          NRST,
   // write port
   input  wire logic [dcf_pkg::DCF_WIDTH-1:0] DATA_IN_BUS,
   input  wire logic                          WRITE_ENABLE_PRIMARY_N,
   input  wire logic                          SECOND_ENABLE_OR_LOAD,
   // read port
   input  wire logic                          READ_ENABLE_A_N,
   input  wire logic                          READ_ENABLE_B_N,
   input  wire logic                          OUTPUT_DRIVE_ENABLE_N,
   output      logic [dcf_pkg::DCF_WIDTH-1:0] DATA_OUT_BUS,
   output      logic                          DATA_OUT_OE,
   // status flags
   output      logic                          FULL_FLAG_N,
   output      logic                          ALMOST_FULL_FLAG_N,
   output      logic                          EMPTY_FLAG_N,
   output      logic                          ALMOST_EMPTY_FLAG_N
);
   import dcf_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   function automatic logic [AW-1:0] ptr_next(input logic [AW-1:0] p);
      ptr_next = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1); // [R26]
   endfunction : ptr_next

   function automatic dcf_ofs_e sel_next(input dcf_ofs_e s);
      case (s)
         OFS_EMPTY_LO : sel_next = OFS_EMPTY_HI;
         OFS_EMPTY_HI : sel_next = OFS_FULL_LO;
         OFS_FULL_LO  : sel_next = OFS_FULL_HI;
         OFS_FULL_HI  : sel_next = OFS_EMPTY_LO;
         default      : sel_next = OFS_EMPTY_LO;
      endcase
   endfunction : sel_next

   logic [DCF_WIDTH-1:0]                   mem_q [DEPTH];
   logic [AW-1:0]                          wr_ptr_q;
   logic [AW-1:0]                          rd_ptr_q;
   logic [CW-1:0]                          arr_cnt_q;
   logic [CW-1:0]                          arr_cnt_d;
   logic [CW-1:0]                          tot_cnt_q;
   logic [CW-1:0]                          tot_cnt_d;
   logic [DCF_OFS_CNT-1:0][DCF_OFS_W-1:0] ofs_q;
   logic [DCF_OFS_CNT-1:0][DCF_OFS_W-1:0] ofs_d;
   dcf_ofs_e                               wsel_q;
   dcf_ofs_e                               rsel_q;
   dcf_flags_s                             flags_q;
   dcf_flags_s                             flags_d;
   logic [DCF_WIDTH-1:0]                   dout_q;
   logic                                   oe_q;
   logic                                   mode_two_q;
   logic                                   buf_in_ready;
   logic                                   buf_out_valid;
   logic [DCF_WIDTH-1:0]                   buf_out_data;

   // mode pin caught on edges while reset is low; reset must span one edge
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         mode_two_q <= SECOND_ENABLE_OR_LOAD; // [R16]
      end
   end

   // decode
   wire        load_sel   = !mode_two_q && !SECOND_ENABLE_OR_LOAD;
   wire        wr_req     = !WRITE_ENABLE_PRIMARY_N && SECOND_ENABLE_OR_LOAD; // [R5] [R6]
   wire        ofs_wr     = !WRITE_ENABLE_PRIMARY_N && load_sel; // [R18] [R19]
   wire        rd_en      = !READ_ENABLE_A_N && !READ_ENABLE_B_N;
   wire        ofs_rd     = rd_en && load_sel; // [R20]
   wire        rd_fire    = rd_en && !load_sel && flags_q.empty_n; // [R10] [R12]
   wire        wr_valid   = wr_req && flags_q.full_n; // [R7]
   wire        wr_fire    = wr_valid && buf_in_ready;
   wire        arr_room   = (arr_cnt_q != CW'(DEPTH));
   wire        push       = buf_out_valid && arr_room;
   wire [15:0] empty_ofs  = {ofs_q[OFS_EMPTY_HI], ofs_q[OFS_EMPTY_LO]};
   wire [15:0] full_ofs   = {ofs_q[OFS_FULL_HI], ofs_q[OFS_FULL_LO]};
   wire [15:0] empty_ofs_d = {ofs_d[OFS_EMPTY_HI], ofs_d[OFS_EMPTY_LO]};
   wire [15:0] full_ofs_d  = {ofs_d[OFS_FULL_HI], ofs_d[OFS_FULL_LO]};

   // next offset image, so the flags never lag a fresh offset write
   always_comb begin
      ofs_d = ofs_q;
      if (ofs_wr) begin
         ofs_d[wsel_q] = DATA_IN_BUS[DCF_OFS_W-1:0]; // [R17] [R18]
      end
   end

   // counts: array count feeds read-side flags, total feeds write-side flags
   assign arr_cnt_d = CW'(arr_cnt_q + CW'(push) - CW'(rd_fire)); // [R26]
   assign tot_cnt_d = CW'(tot_cnt_q + CW'(wr_fire) - CW'(rd_fire)); // [R8] [R13]

   assign flags_d.full_n   = (tot_cnt_d != CW'(DEPTH)); // [R7] [R8]
   assign flags_d.afull_n  = (DCF_CMP_W'(tot_cnt_d) + DCF_CMP_W'(full_ofs_d))
                             < DCF_CMP_W'(DEPTH); // [R25]
   assign flags_d.aempty_n = DCF_CMP_W'(arr_cnt_d) > DCF_CMP_W'(empty_ofs_d); // [R24]
   assign flags_d.empty_n  = (arr_cnt_d != '0); // [R23] [R13]

   // input stage: a stalled array drain refuses writes instead of dropping them
   dcf_buf2 #(
      .W (DCF_WIDTH)
   ) u_in_buf (
      .clk       (SYS_CLK),
      .rst_n     (NRST),
      .in_valid  (wr_valid),
      .in_ready  (buf_in_ready),
      .in_data   (DATA_IN_BUS),
      .out_valid (buf_out_valid),
      .out_ready (arr_room),
      .out_data  (buf_out_data)
   );

   always_ff @(posedge SYS_CLK) begin
      if (push) begin
         mem_q[wr_ptr_q] <= buf_out_data; // [R5]
      end
   end

   // single clock serves both ports, the coincident case
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         wr_ptr_q  <= '0; // [R1]
         rd_ptr_q  <= '0; // [R1]
         arr_cnt_q <= '0;
         tot_cnt_q <= '0;
         flags_q   <= DCF_FLAGS_RST; // [R2]
      end else begin
         wr_ptr_q  <= push ? ptr_next(wr_ptr_q) : wr_ptr_q;
         rd_ptr_q  <= rd_fire ? ptr_next(rd_ptr_q) : rd_ptr_q;
         arr_cnt_q <= arr_cnt_d;
         tot_cnt_q <= tot_cnt_d;
         flags_q   <= flags_d; // [R9] [R14]
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         ofs_q  <= DCF_OFS_RST; // [R3] [R22]
         wsel_q <= OFS_EMPTY_LO;
         rsel_q <= OFS_EMPTY_LO;
      end else begin
         ofs_q <= ofs_d; // [R17]
         if (ofs_wr) begin
            wsel_q <= sel_next(wsel_q); // [R18] [R19]
         end
         if (ofs_rd) begin
            rsel_q <= sel_next(rsel_q); // [R20]
         end
      end
   end

   // output register holds unless a word or an offset is fetched [R11]
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         dout_q <= '0; // [R3]
         oe_q   <= 1'b0;
      end else begin
         oe_q <= !OUTPUT_DRIVE_ENABLE_N; // [R15]
         if (rd_fire) begin
            dout_q <= mem_q[rd_ptr_q]; // [R10]
         end else if (ofs_rd) begin
            dout_q <= DCF_WIDTH'(ofs_q[rsel_q]); // [R20]
         end
      end
   end

   assign DATA_OUT_BUS        = dout_q;
   assign DATA_OUT_OE         = oe_q;
   assign FULL_FLAG_N         = flags_q.full_n;
   assign ALMOST_FULL_FLAG_N  = flags_q.afull_n;
   assign EMPTY_FLAG_N        = flags_q.empty_n;
   assign ALMOST_EMPTY_FLAG_N = flags_q.aempty_n;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!NRST);

   sequence s_full_write;
      !FULL_FLAG_N && wr_req;
   endsequence

   sequence s_count_held;
      tot_cnt_q <= $past(tot_cnt_q);
   endsequence

   chk_full_no_write: assert property (s_full_write |=> s_count_held) // [R7]
      else $error("write taken while full");
   chk_full_level: assert property (FULL_FLAG_N == (tot_cnt_q != CW'(DEPTH))) // [R8]
      else $error("full flag disagrees with count");
   chk_empty_ptr_eq: assert property ( // [R23]
      (rd_ptr_q == wr_ptr_q && arr_cnt_q != CW'(DEPTH)) |-> !EMPTY_FLAG_N)
      else $error("empty flag high with equal pointers");
   chk_empty_ignore: assert property (!EMPTY_FLAG_N |=> $stable(rd_ptr_q)) // [R12]
      else $error("read taken while empty");
   chk_read_hold: assert property ( // [R11]
      (READ_ENABLE_A_N || READ_ENABLE_B_N) |=> $stable(DATA_OUT_BUS))
      else $error("output changed without read enables");
   chk_read_advance: assert property ( // [R10]
      (rd_en && !load_sel && EMPTY_FLAG_N) |=> rd_ptr_q == ptr_next($past(rd_ptr_q)))
      else $error("read did not advance pointer");
   chk_ofs_rotate: assert property ( // [R18]
      ofs_wr |=> (wsel_q == sel_next($past(wsel_q)))
                 && (ofs_q[$past(wsel_q)] == $past(DATA_IN_BUS[DCF_OFS_W-1:0])))
      else $error("offset write out of order");
   chk_aempty_level: assert property ( // [R24]
      ALMOST_EMPTY_FLAG_N == (DCF_CMP_W'(arr_cnt_q) > DCF_CMP_W'(empty_ofs)))
      else $error("almost-empty flag wrong");
   chk_afull_level: assert property ( // [R25]
      ALMOST_FULL_FLAG_N
         == ((DCF_CMP_W'(tot_cnt_q) + DCF_CMP_W'(full_ofs)) < DCF_CMP_W'(DEPTH)))
      else $error("almost-full flag wrong");
   chk_two_en_block: assert property ( // [R6]
      (mode_two_q && !SECOND_ENABLE_OR_LOAD) |=> s_count_held)
      else $error("write without second enable");

   // multi-step flag behaviour
   sequence s_empty_write;
      !EMPTY_FLAG_N && push;
   endsequence

   sequence s_full_read;
      !FULL_FLAG_N && rd_fire;
   endsequence

   sequence s_count_step;
      tot_cnt_q == CW'($past(tot_cnt_q) + 1'b1);
   endsequence

   // port behaviour and reset image
   chk_reset_state: assert property ( // [R1] [R2] [R3] [R22]
      $rose(NRST) |-> (flags_q == DCF_FLAGS_RST) && (DATA_OUT_BUS == '0)
                      && (ofs_q == DCF_OFS_RST) && (wr_ptr_q == '0) && (rd_ptr_q == '0))
      else $error("state after reset wrong");
   chk_write_step: assert property ( // [R5]
      (wr_req && FULL_FLAG_N && !rd_fire) |=> s_count_step)
      else $error("write not counted");
   chk_two_en_store: assert property ( // [R6]
      (mode_two_q && wr_req && FULL_FLAG_N && !rd_fire) |=> s_count_step)
      else $error("two-enable write not counted");
   chk_write_idle: assert property (WRITE_ENABLE_PRIMARY_N |=> s_count_held) // [R5]
      else $error("count rose without write enable");
   chk_load_no_push: assert property (ofs_wr |=> s_count_held) // [R17]
      else $error("offset write entered the buffer");
   chk_sel_persist: assert property (!ofs_wr |=> $stable(wsel_q)) // [R19]
      else $error("write selector moved without offset write");
   chk_ofs_readback: assert property ( // [R20]
      ofs_rd |=> (rsel_q == sel_next($past(rsel_q)))
                 && (DATA_OUT_BUS == DCF_WIDTH'($past(ofs_q[rsel_q]))))
      else $error("offset readback out of order");
   chk_read_data: assert property ( // [R10]
      rd_fire |=> DATA_OUT_BUS == $past(mem_q[rd_ptr_q]))
      else $error("read returned the wrong word");
   chk_ptr_wrap: assert property ( // [R26]
      (rd_fire && rd_ptr_q == AW'(DEPTH - 1)) |=> rd_ptr_q == '0)
      else $error("read pointer did not wrap");
   chk_empty_release: assert property (s_empty_write |=> EMPTY_FLAG_N) // [R13]
      else $error("empty flag stayed low after write");
   chk_full_release: assert property (s_full_read |=> FULL_FLAG_N) // [R8]
      else $error("full flag stayed low after read");
   chk_oe_follow: assert property ( // [R15]
      1'b1 |=> DATA_OUT_OE == !$past(OUTPUT_DRIVE_ENABLE_N))
      else $error("output enable does not follow its pin");
   chk_mode_fixed: assert property (1'b1 |=> $stable(mode_two_q)) // [R16]
      else $error("mode changed outside reset");
   chk_count_bound: assert property ( // [R26]
      (arr_cnt_q <= CW'(DEPTH)) && (tot_cnt_q <= CW'(DEPTH)) && (arr_cnt_q <= tot_cnt_q))
      else $error("word count beyond depth");

endmodule : dcf_fifo

/* File: sim/dcf_peer.sv */
`timescale 1ns/1ps

module dcf_peer (
   // clock
   input  wire logic       clk,
   // writer side
   output      logic [8:0] wd,
   output      logic       wen_n,
   output      logic       sec,
   // reader side
   output      logic       ren_a_n,
   output      logic       ren_b_n
);
   initial begin
      wd      = 9'h000;
      wen_n   = 1'b1;
      sec     = 1'b0;
      ren_a_n = 1'b1;
      ren_b_n = 1'b1;
   end

   task automatic set_sec(input logic v);
      sec = v;
   endtask : set_sec

   // writer and reader never act in the same cycle
   task automatic push(input logic [8:0] d, input logic ld);
      @(posedge clk);
      #1;
      wd    = d;
      wen_n = 1'b0;
      sec   = ld;
      @(posedge clk);
      #1;
      wen_n = 1'b1;
      // stale word is scrambled, not held
      wd    = ~d;
      sec   = 1'b1;
   endtask : push

   task automatic pull(input logic ld, input logic bn);
      @(posedge clk);
      #1;
      sec     = ld;
      ren_a_n = 1'b0;
      ren_b_n = bn;
      @(posedge clk);
      #1;
      ren_a_n = 1'b1;
      ren_b_n = 1'b1;
      sec     = 1'b1;
   endtask : pull
endmodule : dcf_peer

/* File: sim/dcf_fifo_tb.sv */
`timescale 1ns/1ps

module dcf_fifo_tb;
   import dcf_pkg::*;
   localparam int DEP = 16;
   logic       clk  = 1'b0;
   logic       nrst = 1'b0;
   logic       oe_n = 1'b0;
   logic [8:0] wd, q, qbus, fl;
   logic       wen_n, sec, ra_n, rb_n, oe, ff_n, af_n, ef_n, ae_n;
   int         num_errors  = 0;
   int         check_count = 0;

   always #2.5 clk = ~clk;
   assign qbus = oe ? q : {9{1'bZ}};
   assign fl   = {5'h00, ff_n, af_n, ae_n, ef_n};

   dcf_peer peer_u (.clk(clk), .wd(wd), .wen_n(wen_n), .sec(sec),
      .ren_a_n(ra_n), .ren_b_n(rb_n));

   dcf_fifo #(.DEPTH(DEP)) dut_u (.SYS_CLK(clk), .NRST(nrst), .DATA_IN_BUS(wd),
      .WRITE_ENABLE_PRIMARY_N(wen_n), .SECOND_ENABLE_OR_LOAD(sec),
      .READ_ENABLE_A_N(ra_n), .READ_ENABLE_B_N(rb_n), .OUTPUT_DRIVE_ENABLE_N(oe_n),
      .DATA_OUT_BUS(q), .DATA_OUT_OE(oe), .FULL_FLAG_N(ff_n),
      .ALMOST_FULL_FLAG_N(af_n), .EMPTY_FLAG_N(ef_n), .ALMOST_EMPTY_FLAG_N(ae_n));

   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle

   // flags for a word count with full offset 2 and empty offset 3
   function automatic logic [8:0] fexp(input int c);
      return {5'h00, c != DEP, c + 2 < DEP, c > 3, c != 0};
   endfunction : fexp

   // mode pin held through the whole reset
   task automatic do_reset(input logic md);
      nrst = 1'b0;
      peer_u.set_sec(md);
      idle(12);
      nrst = 1'b1;
      peer_u.set_sec(1'b1);
      idle(1);
   endtask : do_reset

   task automatic t_defaults;
      logic [8:0] e[4];
      e = '{9'h007, 9'h000, 9'h007, 9'h000};
      do_reset(1'b0);
      check(fl, 9'h00C);
      check(qbus, 9'h000);
      for (int i = 0; i < 4; i++) begin
         peer_u.pull(1'b0, 1'b0);
         check(qbus, e[i]);
      end
   endtask : t_defaults

   task automatic t_offsets;
      logic [8:0] e[4];
      e = '{9'h003, 9'h000, 9'h002, 9'h000};
      peer_u.push(9'h0AA, 1'b0);
      peer_u.push(9'h000, 1'b0);
      idle(3);
      peer_u.push(9'h002, 1'b0);
      peer_u.push(9'h000, 1'b0);
      peer_u.push(9'h003, 1'b0);
      check(fl, 9'h00C);
      for (int i = 0; i < 4; i++) begin
         peer_u.pull(1'b0, 1'b0);
         check(qbus, e[i]);
      end
   endtask : t_offsets

   task automatic t_fill;
      for (int c = 1; c <= DEP; c++) begin
         peer_u.push(9'(c), 1'b1);
         idle(2);
         check(fl, fexp(c));
      end
      peer_u.push(9'h1FF, 1'b1);
      idle(2);
      check(fl, fexp(DEP));
      peer_u.pull(1'b1, 1'b0);
      check(qbus, 9'h001);
      idle(2);
      check(fl, fexp(DEP - 1));
      peer_u.pull(1'b1, 1'b1);
      check(qbus, 9'h001);
      for (int c = 2; c <= DEP; c++) begin
         peer_u.pull(1'b1, 1'b0);
         check(qbus, 9'(c));
         idle(2);
         check(fl, fexp(DEP - c));
      end
      peer_u.pull(1'b1, 1'b0);
      check(qbus, 9'(DEP));
   endtask : t_fill

   task automatic t_twoen;
      do_reset(1'b1);
      peer_u.push(9'h055, 1'b0);
      idle(2);
      check(fl, fexp(0));
      peer_u.push(9'h0A5, 1'b1);
      idle(2);
      check(fl, fexp(1));
      peer_u.pull(1'b1, 1'b0);
      check(qbus, 9'h0A5);
      oe_n = 1'b1;
      idle(2);
      check(qbus, {9{1'bZ}});
   endtask : t_twoen

   task automatic print_verdict;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      print_verdict();
   end

   initial begin
      t_defaults();
      t_offsets();
      t_fill();
      t_twoen();
      print_verdict();
   end
endmodule : dcf_fifo_tb
